// ### logic/mrc_reset_control.sv
// reset source merge, sequencing and safe pad control
// Functional notes
// - reset comes from external pin, power-on, serial break or watchdog expiry.
// - external pin is active low, filtered by low-frequency oscillator samples.
// - external reset takes effect between 1.5 ms and 4.0 ms after pin assertion.
// - during reset bidirectional pads are inputs, output-only pads other than aux high impedance.
// - I/O, voice in/sync/clock, rx, cts, USB, SPI select/clock/MOSI weakly pulled down.
// - transmit and request-to-send tri-stated with weak pull-ups, idling high.
// - voice serial output and MISO tri-stated with weak pull-downs.
// - auxiliary pad is an output driven low during reset.
`timescale 1ns/1ps
module mrc_reset_control
   import mrc_pkg::*;
#(
   parameter int EXT_MIN_CYC    = mrc_pkg::MRC_EXT_MIN_CYC,
   parameter int EXT_MAX_CYC    = mrc_pkg::MRC_EXT_MAX_CYC,
   parameter int PULSE_HOLD_CYC = mrc_pkg::MRC_PULSE_HOLD_CYC
) (
   // clock and reset
   input  wire logic                            CLK,
   input  wire logic                            RESETN,
   // reset sources
   input  wire logic                            EXTERNAL_RESET_LOW,
   input  wire logic                            LF_TICK,
   input  wire logic                            POR_ACTIVE,
   input  wire logic                            UART_BREAK,
   input  wire logic                            WDOG_EXPIRE,
   // core side
   output logic                                 CORE_RESET_N,
   output logic                                 PADS_SAFE,
   output logic [mrc_pkg::MRC_CAUSE_W-1:0]      RESET_CAUSE,
   // functional pad control from the core
   input  wire logic [mrc_pkg::MRC_NPADS-1:0]   FUNC_OE,
   input  wire logic [mrc_pkg::MRC_NPADS-1:0]   FUNC_OUT,
   input  wire logic [mrc_pkg::MRC_NPADS-1:0]   FUNC_PULL_UP,
   input  wire logic [mrc_pkg::MRC_NPADS-1:0]   FUNC_PULL_DOWN,
   // pad control to the pad ring
   output logic [mrc_pkg::MRC_NPADS-1:0]        PAD_OE,
   output logic [mrc_pkg::MRC_NPADS-1:0]        PAD_OUT,
   output logic [mrc_pkg::MRC_NPADS-1:0]        PAD_PULL_UP,
   output logic [mrc_pkg::MRC_NPADS-1:0]        PAD_PULL_DOWN
);
   import mrc_pkg::*;

   localparam int CNT_W  = $clog2(EXT_MAX_CYC + 1);
   localparam int HOLD_W = $clog2(PULSE_HOLD_CYC + 1);

   if (EXT_MIN_CYC < 1 || EXT_MIN_CYC > EXT_MAX_CYC || PULSE_HOLD_CYC < 1) begin : g_chk
      $error("mrc_reset_control: timing parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // safe masks rebuilt from the pad layout; a packaged mask that drifts
   // from the layout is refused at elaboration instead of reaching silicon
   function automatic logic [MRC_NPADS-1:0] pad_bit(input int idx);
      logic [MRC_NPADS-1:0] m;
      m      = '0;
      m[idx] = 1'b1;
      return m;
   endfunction

   function automatic logic [MRC_NPADS-1:0] in_pd_mask();
      logic [MRC_NPADS-1:0] m;
      m = '0;
      for (int i = MRC_PAD_PIO0; i < MRC_PAD_VIN; i++) begin
         m = m | pad_bit(i);
      end
      m = m | pad_bit(MRC_PAD_VIN) | pad_bit(MRC_PAD_VSYNC) | pad_bit(MRC_PAD_VCLK);
      m = m | pad_bit(MRC_PAD_URX) | pad_bit(MRC_PAD_UCTS);
      m = m | pad_bit(MRC_PAD_USBP) | pad_bit(MRC_PAD_USBN);
      m = m | pad_bit(MRC_PAD_SPISEL) | pad_bit(MRC_PAD_SPICLK) | pad_bit(MRC_PAD_SPIMOSI);
      return m;
   endfunction

   function automatic logic [MRC_NPADS-1:0] out_pu_mask();
      return pad_bit(MRC_PAD_UTX) | pad_bit(MRC_PAD_URTS);
   endfunction

   function automatic logic [MRC_NPADS-1:0] out_pd_mask();
      return pad_bit(MRC_PAD_VOUT) | pad_bit(MRC_PAD_SPIMISO);
   endfunction

   if (MRC_SAFE_OE != pad_bit(MRC_PAD_AUX) || MRC_SAFE_OUT != '0) begin : g_drv_chk
      $error("mrc_reset_control: safe drive masks do not match the pad layout");
   end

   if (MRC_SAFE_PU != out_pu_mask()) begin : g_pu_chk
      $error("mrc_reset_control: safe pull-up mask does not match the pad layout");
   end

   if (MRC_SAFE_PD != (in_pd_mask() | out_pd_mask())) begin : g_pd_chk
      $error("mrc_reset_control: safe pull-down mask does not match the pad layout");
   end

   // a pad pulled both ways would burn current and float mid-rail
   if ((MRC_SAFE_PU & MRC_SAFE_PD) != '0) begin : g_pull_chk
      $error("mrc_reset_control: a pad is pulled both ways");
   end

   typedef struct packed {
      mrc_state_t             state;
      logic                   core_reset_n;
      logic                   pads_safe;
      logic [HOLD_W-1:0]      hold;
      logic [MRC_CAUSE_W-1:0] cause;
      logic [MRC_NPADS-1:0]   oe;
      logic [MRC_NPADS-1:0]   out;
      logic [MRC_NPADS-1:0]   pu;
      logic [MRC_NPADS-1:0]   pd;
   } mrc_ctl_t;

   mrc_ctl_t r;
   mrc_ctl_t next_r;

   logic                   ext_active;
   logic                   level_src;
   logic                   pulse_src;
   logic [MRC_CAUSE_W-1:0] src_now;

   ////////////////////////////////////////////////////////////////////////
   // external pin filter
   mrc_ext_filter #(
      .MIN_CYC (EXT_MIN_CYC),
      .CNT_W   (CNT_W)
   ) u_filt (
      .clk                (CLK),
      .resetn             (RESETN),
      .external_reset_low (EXTERNAL_RESET_LOW),
      .lf_tick            (LF_TICK),
      .ext_active         (ext_active)
   );

   ////////////////////////////////////////////////////////////////////////
   // four sources merged
   always_comb begin
      src_now                 = '0;
      src_now[MRC_CAUSE_EXT]  = ext_active;
      src_now[MRC_CAUSE_POR]  = POR_ACTIVE;
      src_now[MRC_CAUSE_BRK]  = UART_BREAK;
      src_now[MRC_CAUSE_WDOG] = WDOG_EXPIRE;
      level_src               = ext_active | POR_ACTIVE;
      pulse_src               = UART_BREAK | WDOG_EXPIRE;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      unique case (r.state)
         MRC_RUN: begin
            if (level_src || pulse_src) begin
               next_r.state        = MRC_HOLD;
               next_r.core_reset_n = 1'b0;
               next_r.pads_safe    = 1'b1;
               next_r.cause        = src_now;
               next_r.hold         = HOLD_W'(PULSE_HOLD_CYC);
            end
         end
         MRC_HOLD: begin
            next_r.cause = r.cause | src_now;
            // short events stretched so the core sees a full reset
            if (pulse_src) begin
               next_r.hold = HOLD_W'(PULSE_HOLD_CYC);
            end else if (r.hold != '0) begin
               next_r.hold = HOLD_W'(r.hold - 1'b1);
            end
            // release only when every source is gone
            if (!level_src && !pulse_src && r.hold == '0) begin
               next_r.state        = MRC_RELEASE;
               next_r.core_reset_n = 1'b1;
            end
         end
         MRC_RELEASE: begin
            if (level_src || pulse_src) begin
               next_r.state        = MRC_HOLD;
               next_r.core_reset_n = 1'b0;
               next_r.cause        = src_now;
               next_r.hold         = HOLD_W'(PULSE_HOLD_CYC);
            end else begin
               // pads handed back one cycle after release
               next_r.state     = MRC_RUN;
               next_r.pads_safe = 1'b0;
            end
         end
         default: begin
            next_r.state        = MRC_HOLD;
            next_r.core_reset_n = 1'b0;
            next_r.pads_safe    = 1'b1;
         end
      endcase
      // safe pad state overrides the core
      if (next_r.pads_safe) begin
         next_r.oe  = MRC_SAFE_OE;
         next_r.out = MRC_SAFE_OUT;
         next_r.pu  = MRC_SAFE_PU;
         next_r.pd  = MRC_SAFE_PD;
      end else begin
         next_r.oe  = FUNC_OE;
         next_r.out = FUNC_OUT;
         next_r.pu  = FUNC_PULL_UP;
         next_r.pd  = FUNC_PULL_DOWN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pads are in the safe state from the first instant of reset
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         r <= '{state: MRC_HOLD, core_reset_n: 1'b0, pads_safe: 1'b1, hold: '0,
                cause: MRC_CAUSE_RESET, oe: MRC_SAFE_OE, out: MRC_SAFE_OUT,
                pu: MRC_SAFE_PU, pd: MRC_SAFE_PD};
      end else begin
         r <= next_r;
      end
   end

   assign CORE_RESET_N  = r.core_reset_n;
   assign PADS_SAFE     = r.pads_safe;
   assign RESET_CAUSE   = r.cause;
   assign PAD_OE        = r.oe;
   assign PAD_OUT       = r.out;
   assign PAD_PULL_UP   = r.pu;
   assign PAD_PULL_DOWN = r.pd;

endmodule

// ### logic/mrc_pkg.sv
// constants, pad layout and state codes for the module reset control
package mrc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int  MRC_CLK_MHZ        = 250;
   localparam real MRC_EXT_MIN_MS     = 1.5;
   localparam real MRC_EXT_MAX_MS     = 4.0;
   localparam int  MRC_EXT_MIN_CYC    = int'($ceil(MRC_EXT_MIN_MS * 1000.0 * MRC_CLK_MHZ));
   localparam int  MRC_EXT_MAX_CYC    = int'($floor(MRC_EXT_MAX_MS * 1000.0 * MRC_CLK_MHZ));
   // break and watchdog are one-cycle events; stretch them
   localparam int  MRC_PULSE_HOLD_CYC = 64;

   ////////////////////////////////////////////////////////////////////////
   // pad layout
   localparam int MRC_NPADS       = 21;
   localparam int MRC_PAD_PIO0    = 0;
   localparam int MRC_PAD_VIN     = 6;
   localparam int MRC_PAD_VSYNC   = 7;
   localparam int MRC_PAD_VCLK    = 8;
   localparam int MRC_PAD_URX     = 9;
   localparam int MRC_PAD_UCTS    = 10;
   localparam int MRC_PAD_USBP    = 11;
   localparam int MRC_PAD_USBN    = 12;
   localparam int MRC_PAD_SPISEL  = 13;
   localparam int MRC_PAD_SPICLK  = 14;
   localparam int MRC_PAD_SPIMOSI = 15;
   localparam int MRC_PAD_UTX     = 16;
   localparam int MRC_PAD_URTS    = 17;
   localparam int MRC_PAD_VOUT    = 18;
   localparam int MRC_PAD_SPIMISO = 19;
   localparam int MRC_PAD_AUX     = 20;

   // safe pad state while reset is active
   // no drivers except aux
   localparam logic [MRC_NPADS-1:0] MRC_SAFE_OE  = 21'h100000;
   localparam logic [MRC_NPADS-1:0] MRC_SAFE_OUT = 21'h000000;
   localparam logic [MRC_NPADS-1:0] MRC_SAFE_PU  = 21'h030000;
   // voice out and miso pulled down
   localparam logic [MRC_NPADS-1:0] MRC_SAFE_PD  = 21'h0CFFFF;

   ////////////////////////////////////////////////////////////////////////
   // reset cause bits
   localparam int MRC_CAUSE_W    = 4;
   localparam int MRC_CAUSE_EXT  = 0;
   localparam int MRC_CAUSE_POR  = 1;
   localparam int MRC_CAUSE_BRK  = 2;
   localparam int MRC_CAUSE_WDOG = 3;
   localparam logic [MRC_CAUSE_W-1:0] MRC_CAUSE_RESET = 4'h2;

   typedef enum logic [1:0] {
      MRC_RUN     = 2'b00,
      MRC_HOLD    = 2'b01,
      MRC_RELEASE = 2'b10
   } mrc_state_t;

endpackage

// ### logic/mrc_ext_filter.sv
// low-frequency sampled filter and delay for the external reset pin
`timescale 1ns/1ps
module mrc_ext_filter #(
   parameter int MIN_CYC = 375000,
   parameter int CNT_W   = 20
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // pin and slow sample tick
   input  wire logic external_reset_low,
   input  wire logic lf_tick,
   // filtered request
   output logic      ext_active
);
   import mrc_pkg::*;

   typedef struct packed {
      logic [1:0]       samp;
      logic [CNT_W-1:0] cnt;
      logic             active;
   } mrc_filt_t;

   mrc_filt_t r;
   mrc_filt_t next_r;

   if (MIN_CYC < 1 || MIN_CYC >= (1 << CNT_W)) begin : g_chk
      $error("mrc_ext_filter: MIN_CYC does not fit CNT_W");
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      // sampled on the slow oscillator only
      if (lf_tick) begin
         next_r.samp = {r.samp[0], external_reset_low};
      end
      // two equal samples needed, glitches dropped
      if (r.samp == 2'b11) begin
         next_r.cnt    = '0;
         next_r.active = 1'b0;
      end else if (r.samp == 2'b00) begin
         if (r.cnt == CNT_W'(MIN_CYC - 1)) begin
            next_r.active = 1'b1;
         end else begin
            next_r.cnt = CNT_W'(r.cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{samp: 2'b11, cnt: '0, active: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign ext_active = r.active;

endmodule

// ### testbench/mrc_reset_control_props.sv
// port assertions for the module reset control
`timescale 1ns/1ps
module mrc_chk
   import mrc_pkg::*;
#(
   parameter int PULSE_HOLD_CYC = 64
) (
   // clock, reset, sources
   input wire logic                          CLK,
   input wire logic                          RESETN,
   input wire logic                          POR_ACTIVE,
   input wire logic                          UART_BREAK,
   input wire logic                          WDOG_EXPIRE,
   // outputs watched
   input wire logic                          CORE_RESET_N,
   input wire logic                          PADS_SAFE,
   input wire logic [mrc_pkg::MRC_CAUSE_W-1:0] RESET_CAUSE,
   input wire logic [mrc_pkg::MRC_NPADS-1:0] PAD_OE,
   input wire logic [mrc_pkg::MRC_NPADS-1:0] PAD_OUT,
   input wire logic [mrc_pkg::MRC_NPADS-1:0] PAD_PULL_UP,
   input wire logic [mrc_pkg::MRC_NPADS-1:0] PAD_PULL_DOWN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic [7:0] pc;
   ////////////////////////////////
   // cycles since last pulse; saturates so long runs never wrap
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pc <= 8'hFF;
      end else if (UART_BREAK || WDOG_EXPIRE) begin
         pc <= 8'h00;
      end else if (pc != 8'hFF) begin
         pc <= pc + 8'h01;
      end
   end
   sequence pulse_hit;
      (UART_BREAK || WDOG_EXPIRE) && CORE_RESET_N;
   endsequence
   sequence in_reset;
      !CORE_RESET_N && PADS_SAFE;
   endsequence
   ////////////////////////////////
   chk_pulse_enter: assert property (pulse_hit |=> in_reset)
      else $error("pulse did not reset");
   chk_por_hold: assert property (POR_ACTIVE |=> !CORE_RESET_N)
      else $error("por not held");
   chk_cause_brk: assert property (UART_BREAK && CORE_RESET_N |=> RESET_CAUSE[MRC_CAUSE_BRK])
      else $error("break cause lost");
   chk_hold_min: assert property (CORE_RESET_N |-> pc > PULSE_HOLD_CYC)
      else $error("pulse hold too short");
   chk_safe_drive: assert property (PADS_SAFE |-> PAD_OE == MRC_SAFE_OE && PAD_OUT == MRC_SAFE_OUT)
      else $error("unsafe drive");
   chk_safe_pull: assert property (PADS_SAFE |-> PAD_PULL_UP == MRC_SAFE_PU && PAD_PULL_DOWN == MRC_SAFE_PD)
      else $error("unsafe pulls");
   chk_pads_follow: assert property (!CORE_RESET_N |-> PADS_SAFE)
      else $error("pads freed early");
   chk_safe_drop: assert property (CORE_RESET_N && $past(CORE_RESET_N) |-> !PADS_SAFE)
      else $error("pads kept safe");
endmodule
bind mrc_reset_control mrc_chk #(.PULSE_HOLD_CYC(PULSE_HOLD_CYC)) mrc_chk_inst (
   .CLK(CLK), .RESETN(RESETN), .POR_ACTIVE(POR_ACTIVE), .UART_BREAK(UART_BREAK),
   .WDOG_EXPIRE(WDOG_EXPIRE), .CORE_RESET_N(CORE_RESET_N), .PADS_SAFE(PADS_SAFE),
   .RESET_CAUSE(RESET_CAUSE), .PAD_OE(PAD_OE), .PAD_OUT(PAD_OUT),
   .PAD_PULL_UP(PAD_PULL_UP), .PAD_PULL_DOWN(PAD_PULL_DOWN));

// ### testbench/mrc_board_model.sv
// board reset circuit driving the reset pin
`timescale 1ns/1ps
module mrc_board_model (
   // bench control
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] len,
   // pin, pulled up on the board
   output logic             pin_low
);
   logic        req = 1'b0;
   logic [15:0] cnt = 16'h0000;
   initial pin_low = 1'b1;
   always @(posedge clk) req <= go;
   // pin held low for len cycles
   always @(negedge clk) begin
      if (req) begin
         cnt = len;
      end else if (cnt != 16'h0000) begin
         cnt = cnt - 16'h0001;
      end
      pin_low = (cnt == 16'h0000);
   end
endmodule

// ### testbench/tb_mrc_reset_control.sv
// self-checking bench for the module reset control
`timescale 1ns/1ps
module tb_mrc_reset_control;
   import mrc_pkg::*;
   localparam int MIN = 20;
   localparam int MAXC = 40;
   localparam int HOLD = 4;
   logic        CLK = 1'b0;
   logic        RESETN = 1'b0;
   logic        LF_TICK = 1'b0;
   logic        go = 1'b0;
   logic [3:0]  src = 4'h0;
   logic [83:0] func = '0;
   logic [83:0] exp_f = '0;
   logic [15:0] len = 16'h0000;
   logic [31:0] lfsr = 32'hF89B;
   wire         pin;
   wire         crn;
   wire         safe;
   wire  [3:0]  cause;
   wire  [83:0] pads;
   int          bad_count = 0;
   int          comparisons = 0;
   int          tick = 0;
   int          d;
   ////////////////////////////////
   mrc_reset_control #(.EXT_MIN_CYC(MIN), .EXT_MAX_CYC(MAXC), .PULSE_HOLD_CYC(HOLD)) mrc_reset_control_inst (
      .CLK(CLK), .RESETN(RESETN), .EXTERNAL_RESET_LOW(pin), .LF_TICK(LF_TICK), .POR_ACTIVE(src[1]),
      .UART_BREAK(src[2]), .WDOG_EXPIRE(src[3]), .CORE_RESET_N(crn), .PADS_SAFE(safe), .RESET_CAUSE(cause),
      .FUNC_OE(func[83:63]), .FUNC_OUT(func[62:42]), .FUNC_PULL_UP(func[41:21]), .FUNC_PULL_DOWN(func[20:0]),
      .PAD_OE(pads[83:63]), .PAD_OUT(pads[62:42]), .PAD_PULL_UP(pads[41:21]), .PAD_PULL_DOWN(pads[20:0]));
   mrc_board_model mrc_board_model_inst (.clk(CLK), .go(go), .len(len), .pin_low(pin));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always #2 CLK = ~CLK;
   // model: pads follow core control one edge late
   always @(posedge CLK) exp_f <= func;
   always @(negedge CLK) begin
      tick = (tick + 1) % 6;
      LF_TICK = (tick == 0);
      lfsr = nxt(lfsr);
      func = {lfsr[20:0], lfsr[31:11], ~lfsr[20:0], lfsr[25:5]};
   end
   ////////////////////////////////
   task automatic chk(input logic [84:0] g, input logic [84:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic padchk(input logic s);
      chk({safe, pads}, s ? {1'b1, MRC_SAFE_OE, MRC_SAFE_OUT, MRC_SAFE_PU, MRC_SAFE_PD} : {1'b0, exp_f});
   endtask
   task automatic wait_rel();
      d = 0;
      while (crn !== 1'b1 && d < 300) begin
         cyc(1);
         d++;
      end
   endtask
   task automatic fire(input int s, input int n);
      src = 4'h1 << s;
      cyc(n);
      src = 4'h0;
      wait_rel();
   endtask
   task automatic pin_pulse(input logic [15:0] n);
      len = n;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      d = 0;
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////
   initial begin
      cyc(20);
      RESETN = 1'b1;
      cyc(1);
      chk(crn, 1'b1);
      chk(cause, MRC_CAUSE_RESET);
      padchk(1'b1);
      repeat (30) begin
         cyc(1);
         padchk(1'b0);
      end
      // por level, then break and watchdog pulses
      for (int s = 1; s < 4; s++) begin
         fire(s, s == 1 ? 10 : 1);
         chk(cause, 4'h1 << s);
         if (s > 1) chk(d, HOLD + 1);
         padchk(1'b1);
         cyc(1);
         padchk(1'b0);
      end
      // watchdog in the release cycle re-enters reset
      fire(2, 1);
      fire(3, 1);
      chk(cause, 4'h8);
      chk(d, HOLD + 1);
      cyc(2);
      pin_pulse(16'd60);
      while (crn === 1'b1 && d < 300) begin
         cyc(1);
         d++;
      end
      chk(d >= MIN && d <= MAXC, 1'b1);
      chk(cause, 4'h1);
      wait_rel();
      cyc(2);
      padchk(1'b0);
      // short glitch seen on at most one slow sample
      pin_pulse(16'd3);
      repeat (60) begin
         cyc(1);
         if (crn !== 1'b1) d++;
      end
      chk(d, 0);
      print_verdict();
   end
   initial begin
      cyc(4000);
      bad_count++;
      print_verdict();
   end
endmodule
